// ### inc/flash_cmd_pkg.sv
package flash_cmd_pkg;

	// Command codes seen on the serial input.
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_ERASE_32K    = 8'h52;
	localparam logic [7:0] OP_ERASE_64K    = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
	localparam logic [7:0] OP_RELEASE_ID   = 8'hAB;
	localparam logic [7:0] OP_MAKER_ID     = 8'h90;

	// Bit counts that close each part of a frame.
	localparam logic [6:0] BITS_OPCODE   = 7'h08;
	localparam logic [6:0] BITS_ADDR_END = 7'h20;
	localparam logic [6:0] BITS_SAT      = 7'h7F;

	// Address that swaps the order of the two identification bytes.
	localparam logic [23:0] ID_SWAP_ADDR = 24'h000001;

	// Array geometry: 8 Mbit, counted in 64 KB blocks.
	localparam int ADDR_W  = 20;
	localparam int BLK_LSB = 16;
	localparam int BLK_W   = ADDR_W - BLK_LSB;

	// Status byte layout.
	localparam int ST_WIP    = 0;
	localparam int ST_WEL    = 1;
	localparam int ST_BP_LSB = 2;
	localparam int ST_W      = 5;

	// Identification bytes; the values are arbitrary.
	localparam logic [7:0] MAKER_ID_DEF  = 8'h5A;
	localparam logic [7:0] DEVICE_ID_DEF = 8'h13;

	// Timing figures in their own units and their cycle counts at 10 MHz.
	localparam int CLK_KHZ          = 10_000;
	localparam int PD_ENTRY_NS      = 3_000;
	localparam int RELEASE_NS       = 3_000;
	localparam int RELEASE_ID_NS    = 3_000;
	localparam int BLK_ERASE_MS     = 150;
	localparam int CHIP_ERASE_MS    = 8_000;
	localparam int PD_ENTRY_CYC     = (PD_ENTRY_NS * CLK_KHZ + 999_999) / 1_000_000;
	localparam int RELEASE_CYC      = (RELEASE_NS * CLK_KHZ + 999_999) / 1_000_000;
	localparam int RELEASE_ID_CYC   = (RELEASE_ID_NS * CLK_KHZ + 999_999) / 1_000_000;
	localparam int BLK_ERASE_CYC    = BLK_ERASE_MS * CLK_KHZ;
	localparam int CHIP_ERASE_CYC   = CHIP_ERASE_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		ERASE_32K  = 2'h0,
		ERASE_64K  = 2'h1,
		ERASE_CHIP = 2'h2
	} erase_kind_e;

	// Gray-coded along standby, entering, down, waking, standby.
	typedef enum logic [1:0] {
		PWR_ON    = 2'h0,
		PWR_ENTER = 2'h1,
		PWR_DOWN  = 2'h3,
		PWR_WAKE  = 2'h2
	} pwr_state_e;

endpackage

// ### logic/flash_cmd_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Opcode 52H plus three address bytes erases the 32 KB block holding it.
// - Opcode D8H plus three address bytes erases the 64 KB block holding it.
// - Any erase needs the write-enable latch set beforehand.
// - Block erase runs only if select rises right after the 32nd bit.
// - A valid erase sets write-in-progress until done and clears the latch.
// - A block erase into the protected region is refused.
// - Chip erase takes 60H or C7H and needs select rising after bit 8.
// - Chip erase runs only when all three protect bits are zero.
// - B9H with select rising after bit 8 powers down after the entry delay.
// - In power-down every command except release/read-ID is ignored.
// - Power-down is refused while any write or erase cycle runs.
// - Reset always comes up in standby, never in power-down.
// - ABH alone releases power-down; nothing is accepted for the release delay.
// - ABH plus three dummy bytes repeats the ID MSB first on falling edges.
// - Release with ID read waits the ID release delay, equal to the plain release delay, before commands.
// - Release/read-ID is ignored while write-in-progress is set.
// - 90H with address 0 sends maker then device ID, MSB first.
// - 90H with address 1 sends the device ID first.
// - Opcode and address bits are sampled on rising serial clock edges.
// - Status read 05H works at any time outside power-down and the release delay, even during a cycle.
module flash_cmd_ctrl
	import flash_cmd_pkg::*;
#(
	parameter int         BLK_ERASE_CYCLES  = BLK_ERASE_CYC,
	parameter int         CHIP_ERASE_CYCLES = CHIP_ERASE_CYC,
	parameter logic [7:0] MAKER_ID          = MAKER_ID_DEF,
	parameter logic [7:0] DEVICE_ID         = DEVICE_ID_DEF
) (
	input  wire logic              clk,              // System clock, 10 MHz.
	input  wire logic              rst_n,            // Synchronous reset, active low.
	input  wire logic              sclk,             // Serial clock from the host.
	input  wire logic              csN,              // Chip select, active low.
	input  wire logic              si,               // Serial data in.
	output logic                   so,               // Serial data out.
	output logic                   soOe,             // Serial data out enable.
	input  wire logic [2:0]        protectSel,       // Block-protect bits 2..0.
	input  wire logic              otherBusy,        // A program or write cycle runs.
	output logic                   writeInProgress,  // Self-timed cycle running.
	output logic                   writeEnableLatch, // Write-enable latch.
	output logic                   powerDown,        // Deep power-down state.
	output logic                   eraseStart,       // One-cycle pulse, erase begins.
	output erase_kind_e            eraseKind,        // Kind of running erase.
	output logic [ADDR_W-1:0]      eraseAddr,        // Address of running erase.
	output logic                   eraseDone         // One-cycle pulse, erase ends.
);

	// ---------------- Link side, rising edges of sclk ----------------
	logic              inFrame_r;
	logic [6:0]        bitCnt_r;
	logic [7:0]        opcode_r;
	logic [23:0]       addr_r;
	logic [3:0]        outPos_r;
	logic [6:0]        dataStart;

	// Output starts after the opcode for status, after 32 bits for ID reads.
	assign dataStart = (opcode_r == OP_READ_STATUS) ? BITS_OPCODE : BITS_ADDR_END;

	// The frame flag is cleared by select; the counts survive the frame end
	// so that the system side can judge the frame after select rises.
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			inFrame_r <= 1'b0;
		end else begin
			inFrame_r <= 1'b1;
		end
	end

	always_ff @(posedge sclk) begin
		if (!inFrame_r) begin
			bitCnt_r <= 7'h01;
		end else if (bitCnt_r != BITS_SAT) begin
			bitCnt_r <= bitCnt_r + 7'h01;
		end
	end

	always_ff @(posedge sclk) begin
		if (!inFrame_r) begin
			opcode_r <= {7'h00, si};
		end else if (bitCnt_r < BITS_OPCODE) begin
			opcode_r <= {opcode_r[6:0], si};
		end else if (bitCnt_r < BITS_ADDR_END) begin
			addr_r <= {addr_r[22:0], si};
		end
	end

	always_ff @(posedge sclk) begin
		if (!inFrame_r) begin
			outPos_r <= 4'h0;
		end else if (bitCnt_r >= dataStart) begin
			outPos_r <= outPos_r + 4'h1;
		end
	end

	// ---------------- Link side, falling edges of sclk ----------------
	logic [ST_W-1:0] statusS1_r;
	logic [ST_W-1:0] statusS2_r;
	logic            dormantS1_r;
	logic            dormantS2_r;
	logic            waitS1_r;
	logic            waitS2_r;
	logic [ST_W-1:0] statusNow;
	logic            dormantNow;
	logic            waitNow;
	logic [7:0]      firstId;
	logic [7:0]      secondId;
	logic [7:0]      outByte;
	logic            outValid;
	logic            so_r;
	logic            soOe_r;

	always_ff @(negedge sclk) begin
		statusS1_r  <= statusNow;
		statusS2_r  <= statusS1_r;
		dormantS1_r <= dormantNow;
		dormantS2_r <= dormantS1_r;
		waitS1_r    <= waitNow;
		waitS2_r    <= waitS1_r;
	end

	assign firstId  = (addr_r == ID_SWAP_ADDR) ? DEVICE_ID : MAKER_ID;
	assign secondId = (addr_r == ID_SWAP_ADDR) ? MAKER_ID : DEVICE_ID;

	always_comb begin
		outByte  = 8'h00;
		outValid = 1'b0;
		if (inFrame_r && bitCnt_r >= dataStart && !waitS2_r) begin
			unique case (opcode_r)
				OP_READ_STATUS: begin
					outByte  = {{(8 - ST_W){1'b0}}, statusS2_r};
					outValid = !dormantS2_r;
				end
				OP_RELEASE_ID: begin
					outByte  = DEVICE_ID;
					outValid = !statusS2_r[ST_WIP];
				end
				OP_MAKER_ID: begin
					outByte  = outPos_r[3] ? secondId : firstId;
					outValid = !dormantS2_r;
				end
				default: begin
					outByte  = 8'h00;
					outValid = 1'b0;
				end
			endcase
		end
	end

	// Data leaves MSB first on falling edges and repeats while selected.
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			so_r   <= 1'b0;
			soOe_r <= 1'b0;
		end else begin
			so_r   <= outByte[3'h7 - outPos_r[2:0]];
			soOe_r <= outValid;
		end
	end

	assign so   = so_r;
	assign soOe = soOe_r & !csN;

	// ---------------- System side ----------------
	logic            csS1_r;
	logic            csS2_r;
	logic            csS3_r;
	logic            csRise;
	pwr_state_e      pwr_r;
	logic [15:0]     pwrCnt_r;
	logic [31:0]     busyCnt_r;
	logic            wel_r;
	logic            erasing_r;
	logic            dormant;
	logic            locked;
	logic            write_in_progress;
	logic            bitsOpcode;
	logic            bitsAddr;
	logic            isChip;
	logic            blockHit;
	logic            eraseOk;
	logic            pdOk;

	function automatic logic isProtected(input logic [BLK_W-1:0] blk, input logic [2:0] bp);
		logic [7:0] span;
		logic [7:0] total;
		span  = 8'h01 << (bp - 3'h1);
		total = 8'h01 << BLK_W;
		return (bp != 3'h0) && ((span >= total) || ({4'h0, blk} >= total - span));
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			csS1_r <= 1'b1;
			csS2_r <= 1'b1;
			csS3_r <= 1'b1;
		end else begin
			csS1_r <= csN;
			csS2_r <= csS1_r;
			csS3_r <= csS2_r;
		end
	end

	assign csRise     = csS2_r & !csS3_r;
	assign dormant    = (pwr_r == PWR_ENTER) || (pwr_r == PWR_DOWN);
	assign locked     = (pwr_r == PWR_WAKE);
	assign write_in_progress        = (busyCnt_r != 32'h0) || otherBusy;
	assign bitsOpcode = (bitCnt_r == BITS_OPCODE);
	assign bitsAddr   = (bitCnt_r == BITS_ADDR_END);
	assign isChip     = (opcode_r == OP_CHIP_ERASE_A) || (opcode_r == OP_CHIP_ERASE_B);
	assign blockHit   = isProtected(addr_r[ADDR_W-1:BLK_LSB], protectSel);
	assign statusNow  = {protectSel, wel_r, write_in_progress};
	assign dormantNow = dormant;
	assign waitNow    = locked;

	// The whole frame is judged once select has risen; a wrong count drops it.
	always_comb begin
		eraseOk = 1'b0;
		if (csRise && !dormant && !locked && !write_in_progress && wel_r) begin
			if (opcode_r == OP_ERASE_32K || opcode_r == OP_ERASE_64K) begin
				eraseOk = bitsAddr && !blockHit;
			end else if (isChip) begin
				eraseOk = bitsOpcode && (protectSel == 3'h0);
			end
		end
	end

	assign pdOk = csRise && !dormant && !locked && !write_in_progress && bitsOpcode
		&& (opcode_r == OP_POWER_DOWN);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wel_r <= 1'b0;
		end else if (eraseOk) begin
			wel_r <= 1'b0;
		end else if (csRise && !dormant && !locked && !write_in_progress && bitsOpcode
			&& opcode_r == OP_WRITE_ENABLE) begin
			wel_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busyCnt_r <= 32'h0;
		end else if (eraseOk) begin
			busyCnt_r <= isChip ? 32'(CHIP_ERASE_CYCLES) : 32'(BLK_ERASE_CYCLES);
		end else if (busyCnt_r != 32'h0) begin
			busyCnt_r <= busyCnt_r - 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			erasing_r <= 1'b0;
			eraseStart <= 1'b0;
			eraseDone <= 1'b0;
			eraseKind <= ERASE_32K;
			eraseAddr <= '0;
		end else begin
			eraseStart <= eraseOk;
			eraseDone  <= erasing_r && (busyCnt_r == 32'h1);
			if (eraseOk) begin
				erasing_r <= 1'b1;
				eraseAddr <= addr_r[ADDR_W-1:0];
				if (isChip) begin
					eraseKind <= ERASE_CHIP;
				end else if (opcode_r == OP_ERASE_64K) begin
					eraseKind <= ERASE_64K;
				end else begin
					eraseKind <= ERASE_32K;
				end
			end else if (busyCnt_r == 32'h1) begin
				erasing_r <= 1'b0;
			end
		end
	end

	// Power state: reset always lands in standby.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwr_r    <= PWR_ON;
			pwrCnt_r <= 16'h0;
		end else begin
			unique case (pwr_r)
				PWR_ON: begin
					if (pdOk) begin
						pwr_r    <= PWR_ENTER;
						pwrCnt_r <= 16'(PD_ENTRY_CYC);
					end
				end
				PWR_ENTER, PWR_DOWN: begin
					if (pwr_r == PWR_ENTER && pwrCnt_r == 16'h1) begin
						pwr_r <= PWR_DOWN;
					end
					if (pwrCnt_r != 16'h0) begin
						pwrCnt_r <= pwrCnt_r - 16'h1;
					end
					if (csRise && opcode_r == OP_RELEASE_ID && !write_in_progress) begin
						if (bitsOpcode) begin
							pwr_r    <= PWR_WAKE;
							pwrCnt_r <= 16'(RELEASE_CYC);
						end else if (bitCnt_r >= BITS_ADDR_END) begin
							pwr_r    <= PWR_WAKE;
							pwrCnt_r <= 16'(RELEASE_ID_CYC);
						end
					end
				end
				PWR_WAKE: begin
					if (pwrCnt_r <= 16'h1) begin
						pwr_r    <= PWR_ON;
						pwrCnt_r <= 16'h0;
					end else begin
						pwrCnt_r <= pwrCnt_r - 16'h1;
					end
				end
			endcase
		end
	end

	assign writeInProgress  = write_in_progress;
	assign writeEnableLatch = wel_r;
	assign powerDown        = (pwr_r == PWR_DOWN);

endmodule // flash_cmd_ctrl

// ### tb/flash_cmd_ctrl_assertions.sv
`timescale 1ns/10ps
module flash_cmd_ctrl_assertions
	import flash_cmd_pkg::*;
#(
	parameter int BLK_ERASE_CYCLES  = 50,
	parameter int CHIP_ERASE_CYCLES = 80
) (
	input wire logic              clk,              // Clock.
	input wire logic              rst_n,            // Reset.
	input wire logic              csN,              // Select.
	input wire logic              soOe,             // Out enable.
	input wire logic [2:0]        protectSel,       // Protect bits.
	input wire logic              writeInProgress,  // Busy.
	input wire logic              writeEnableLatch, // Latch.
	input wire logic              powerDown,        // Down.
	input wire logic              eraseStart,       // Start.
	input wire erase_kind_e       eraseKind,        // Kind.
	input wire logic              eraseDone         // Done.
);
	int eraseCnt_r;
	int eraseLen;
	assign eraseLen = (eraseKind == ERASE_CHIP) ? CHIP_ERASE_CYCLES : BLK_ERASE_CYCLES;
	always_ff @(posedge clk) begin
		if (!rst_n || eraseStart) begin
			eraseCnt_r <= 0;
		end else if (eraseCnt_r < 1000000) begin
			eraseCnt_r <= eraseCnt_r + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_erase_length: assert property (eraseDone |->
		eraseCnt_r + 2 >= eraseLen && eraseCnt_r <= eraseLen + 1) else $error("erase length off");
	a_busy_held: assert property (eraseStart |-> writeInProgress [*8])
		else $error("busy not held");
	a_latch_cleared: assert property (eraseStart |-> ##[0:1] !writeEnableLatch)
		else $error("latch kept");
	a_select_closed: assert property (eraseStart |-> $past(csN) && $past(csN, 2))
		else $error("erase while selected");
	a_chip_unprotected: assert property (eraseStart && eraseKind == ERASE_CHIP |->
		protectSel == 3'h0) else $error("chip erase protected");
	a_down_idle: assert property ($rose(powerDown) |-> !writeInProgress)
		else $error("down while busy");
	a_down_quiet: assert property (powerDown |-> !eraseStart)
		else $error("erase while down");
	a_oe_selected: assert property (soOe |-> !csN)
		else $error("drive while deselected");
	a_latch_fall: assert property ($fell(writeEnableLatch) |->
		eraseStart || $past(eraseStart)) else $error("latch lost");
endmodule // flash_cmd_ctrl_assertions

bind flash_cmd_ctrl flash_cmd_ctrl_assertions #(.BLK_ERASE_CYCLES(BLK_ERASE_CYCLES),
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)) chk_u (.clk(clk), .rst_n(rst_n), .csN(csN),
	.soOe(soOe), .protectSel(protectSel), .writeInProgress(writeInProgress),
	.writeEnableLatch(writeEnableLatch), .powerDown(powerDown), .eraseStart(eraseStart),
	.eraseKind(eraseKind), .eraseDone(eraseDone));

// ### tb/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
	output logic      sclk, // Serial clock.
	output logic      csN,  // Select.
	output logic      si,   // Data out.
	input  wire logic so,   // Data in.
	input  wire logic soOe  // Device drives so.
);
	logic oeSeen;
	// A select pulse at start-up gives the select-cleared link flops a defined edge.
	initial begin
		sclk = 1'b0;
		csN = 1'b0;
		si = 1'b0;
		#1 csN = 1'b1;
	end
	always @(posedge soOe) oeSeen = 1'b1;
	// Clock stands low between frames; data is moved only while the clock is low.
	task automatic frame(input logic [31:0] tx, input int n, input int nRd,
		output logic [15:0] rd);
		rd = 16'h0;
		oeSeen = 1'b0;
		csN = 1'b0;
		for (int i = 0; i < n + nRd; i++) begin
			si = (i < 32) ? tx[31 - i] : ~si;
			#24 sclk = 1'b1;
			if (i >= n) rd = {rd[14:0], so};
			#24 sclk = 1'b0;
		end
		#24 csN = 1'b1;
		si = ~si;
		#500;
	endtask
endmodule // spi_host_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import flash_cmd_pkg::*;
	logic              clk, rst_n, otherBusy, sclk, csN, si, so, soOe;
	logic              write_in_progress, write_enable_latch, pd, eStart, eDone;
	logic [2:0]        protectSel;
	erase_kind_e       eKind, kindSeen;
	logic [ADDR_W-1:0] eAddr, addrSeen;
	logic [15:0]       rd;
	int                mismatches, tests_run, starts, s0, dones;
	flash_cmd_ctrl #(.BLK_ERASE_CYCLES(50), .CHIP_ERASE_CYCLES(80)) dut_u (.clk(clk),
		.rst_n(rst_n), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe),
		.protectSel(protectSel), .otherBusy(otherBusy), .writeInProgress(write_in_progress),
		.writeEnableLatch(write_enable_latch), .powerDown(pd), .eraseStart(eStart), .eraseKind(eKind),
		.eraseAddr(eAddr), .eraseDone(eDone));
	spi_host_model host_u (.sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (eStart === 1'b1) begin
			starts++;
			kindSeen = eKind;
			addrSeen = eAddr;
		end
		if (eDone === 1'b1) begin
			dones++;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
		s0 = starts;
		host_u.frame({op, a}, n, 0, rd);
	endtask
	task automatic waitIdle();
		for (int i = 0; i < 200 && write_in_progress !== 1'b0; i++) tick(1);
	endtask
	task summarize;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		mismatches++;
		summarize;
	end
	initial begin
		rst_n = 1'b0;
		otherBusy = 1'b0;
		protectSel = 3'h0;
		tick(8);
		rst_n = 1'b1;
		tick(4);
		chk("powerDown", 0, pd);
		host_u.frame({OP_MAKER_ID, 24'h0}, 32, 16, rd);
		chk("ids", {MAKER_ID_DEF, DEVICE_ID_DEF}, rd);
		host_u.frame({OP_MAKER_ID, ID_SWAP_ADDR}, 32, 16, rd);
		chk("swapped ids", {DEVICE_ID_DEF, MAKER_ID_DEF}, rd);
		host_u.frame({OP_RELEASE_ID, 24'h0}, 32, 16, rd);
		chk("device id", {2{DEVICE_ID_DEF}}, rd);
		send(OP_ERASE_32K, 24'h012345, 32);
		send(OP_WRITE_ENABLE, 24'h0, 8);
		send(OP_ERASE_32K, 24'h012345, 31);
		chk("dropped starts", 0, starts);
		chk("latch kept", 1, write_enable_latch);
		tick(1);
		protectSel = 3'h1;
		send(OP_ERASE_32K, 24'h012345, 32);
		chk("kind", ERASE_32K, kindSeen);
		chk("addr", 20'h12345, addrSeen);
		chk("busy latch", 2'b10, {write_in_progress, write_enable_latch});
		host_u.frame({OP_READ_STATUS, 24'h0}, 8, 8, rd);
		chk("status", 8'h05, rd[7:0]);
		send(OP_POWER_DOWN, 24'h0, 8);
		waitIdle();
		chk("busy down", 2'b00, {write_in_progress, pd});
		send(OP_WRITE_ENABLE, 24'h0, 8);
		send(OP_ERASE_64K, 24'h0F0000, 32);
		chk("protected", s0, starts);
		send(OP_ERASE_64K, 24'h0E8000, 32);
		chk("kind", {ERASE_64K, 20'hE8000}, {kindSeen, addrSeen});
		waitIdle();
		for (int k = 0; k < 2; k++) begin
			tick(1);
			protectSel = 3'h1;
			send(OP_WRITE_ENABLE, 24'h0, 8);
			send(k ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 24'h0, 8);
			chk("chip protected", s0, starts);
			tick(1);
			protectSel = 3'h0;
			send(k ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 24'h0, 9);
			chk("chip long", s0, starts);
			send(k ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 24'h0, 8);
			chk("chip", {8'(s0 + 1), ERASE_CHIP, 1'b0}, {8'(starts), kindSeen, write_enable_latch});
			waitIdle();
		end
		send(OP_POWER_DOWN, 24'h0, 9);
		tick(40);
		chk("down long", 0, pd);
		send(OP_POWER_DOWN, 24'h0, 8);
		tick(32);
		chk("down", 1, pd);
		send(OP_WRITE_ENABLE, 24'h0, 8);
		host_u.frame({OP_MAKER_ID, 24'h0}, 32, 8, rd);
		chk("ignored", 2'b00, {write_enable_latch, host_u.oeSeen});
		send(OP_RELEASE_ID, 24'h0, 8);
		send(OP_WRITE_ENABLE, 24'h0, 8);
		chk("release", 2'b00, {pd, write_enable_latch});
		tick(40);
		send(OP_WRITE_ENABLE, 24'h0, 8);
		chk("after release", 1, write_enable_latch);
		send(OP_POWER_DOWN, 24'h0, 8);
		tick(32);
		host_u.frame({OP_RELEASE_ID, 24'h0}, 32, 8, rd);
		chk("long release", {1'b0, DEVICE_ID_DEF}, {pd, rd[7:0]});
		tick(40);
		otherBusy = 1'b1;
		send(OP_POWER_DOWN, 24'h0, 8);
		host_u.frame({OP_RELEASE_ID, 24'h0}, 32, 8, rd);
		tick(40);
		chk("busy refusals", 3'b100, {write_in_progress, pd, host_u.oeSeen});
		otherBusy = 1'b0;
		tick(4);
		chk("erase starts", 4, starts);
		chk("erase ends", 4, dones);
		summarize;
	end
endmodule // tb_top
